// [logic/afc_ctrl.sv]
`timescale 1ns/1ns
// How it works
// - host must reset the device before its first write.
// - host keeps both strobes high before and after reset rises.
// - write strobe falls only while not full; data stable around its rise.
// - host keeps both strobes high while pulsing rewind.
// - expansion input low selects single mode with rewind and half-full.
// - chained mode: first device first-load low, others high.
// - host combines all empty flags and all full flags in chained mode.
module afc_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic reset_n_in,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic first_load_or_rewind_n,
  output logic chain_in_n,
  output logic [afc_pkg::DATA_W-1:0] write_data_bus,
  input wire logic [afc_pkg::DATA_W-1:0] read_data_bus,
  input wire logic [afc_pkg::CHAIN_LEN-1:0] full_ind_n,
  input wire logic [afc_pkg::CHAIN_LEN-1:0] empty_ind_n,
  input wire logic chain_out_or_half_full_n
);
  import afc_pkg::*;

  typedef struct packed {
    afc_state_type state;
    logic [CNT_W-1:0] cnt;
    logic write_n;
    logic read_n;
    logic reset_n;
    logic rewind_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic reset_done;
    logic refused;
  } afc_ctrl_state_type;

  afc_ctrl_state_type s_reg;
  afc_ctrl_state_type s_next;

  logic expansion_mode;
  logic first_load_level;
  logic [DATA_W-1:0] wdata_sw;
  logic start_write;
  logic start_read;
  logic start_reset;
  logic start_rewind;
  logic clear_refused;
  logic full_ok;
  logic empty_ok;
  logic half_n;
  logic busy;

  // composite flag: high while any device in use is not blocking
  function automatic logic flag_combine(input logic [CHAIN_LEN-1:0] flags_n,
                                        input logic chained);
    return chained ? (|flags_n) : flags_n[0];
  endfunction : flag_combine

  // ==========================================
  // register slave
  afc_ahb_regs u_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .expansion_mode(expansion_mode),
    .first_load_level(first_load_level),
    .wdata(wdata_sw),
    .start_write(start_write),
    .start_read(start_read),
    .start_reset(start_reset),
    .start_rewind(start_rewind),
    .clear_refused(clear_refused),
    .busy(busy),
    .full_n(full_ok),
    .empty_n(empty_ok),
    .half_n(half_n),
    .reset_done(s_reg.reset_done),
    .refused(s_reg.refused),
    .rdata(s_reg.rdata)
  );

  // ==========================================
  // flags
  // composite flags
  assign full_ok = flag_combine(full_ind_n, expansion_mode);
  assign empty_ok = flag_combine(empty_ind_n, expansion_mode);
  assign half_n = expansion_mode ? 1'b1 : chain_out_or_half_full_n;
  assign busy = (s_reg.state != ST_IDLE);

  // ==========================================
  // pin sequencer
  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - CNT_ONE;
    end
    if (clear_refused) begin
      s_next.refused = 1'b0;
    end
    case (s_reg.state)
      ST_IDLE: begin
        if (start_reset) begin
          s_next.state = ST_RST_SETUP;
          s_next.cnt = RST_SETUP_CYC - CNT_ONE;
        end else if (start_write) begin
          // write only after reset and not full
          if (s_reg.reset_done && full_ok) begin
            s_next.wdata = wdata_sw;
            s_next.write_n = 1'b0;
            s_next.state = ST_WR_LOW;
            s_next.cnt = STROBE_CYC - CNT_ONE;
          end else begin
            s_next.refused = 1'b1;
          end
        end else if (start_read) begin
          // read only when composite not empty
          if (s_reg.reset_done && empty_ok) begin
            s_next.read_n = 1'b0;
            s_next.state = ST_RD_LOW;
            s_next.cnt = STROBE_CYC - CNT_ONE;
          end else begin
            s_next.refused = 1'b1;
          end
        end else if (start_rewind) begin
          if (s_reg.reset_done && !expansion_mode) begin
            s_next.state = ST_RT_SETUP;
            s_next.cnt = RT_SETUP_CYC - CNT_ONE;
          end else begin
            s_next.refused = 1'b1;
          end
        end
      end
      ST_WR_LOW: begin
        if (s_reg.cnt == '0) begin
          s_next.write_n = 1'b1;
          s_next.state = ST_RECOVER;
          s_next.cnt = FLAG_CYC - CNT_ONE;
        end
      end
      ST_RD_LOW: begin
        if (s_reg.cnt == '0) begin
          s_next.rdata = read_data_bus;
          s_next.read_n = 1'b1;
          s_next.state = ST_RECOVER;
          s_next.cnt = FLAG_CYC - CNT_ONE;
        end
      end
      ST_RST_SETUP: begin
        if (s_reg.cnt == '0) begin
          s_next.reset_n = 1'b0;
          s_next.state = ST_RST_LOW;
          s_next.cnt = RST_PULSE_CYC - CNT_ONE;
        end
      end
      ST_RST_LOW: begin
        if (s_reg.cnt == '0) begin
          s_next.reset_n = 1'b1;
          s_next.reset_done = 1'b1;
          s_next.state = ST_RECOVER;
          s_next.cnt = RST_RECOV_CYC + FLAG_CYC - CNT_ONE;
        end
      end
      ST_RT_SETUP: begin
        if (s_reg.cnt == '0) begin
          s_next.rewind_n = 1'b0;
          s_next.state = ST_RT_LOW;
          s_next.cnt = RT_PULSE_CYC - CNT_ONE;
        end
      end
      ST_RT_LOW: begin
        if (s_reg.cnt == '0) begin
          s_next.rewind_n = 1'b1;
          s_next.state = ST_RECOVER;
          s_next.cnt = RT_RECOV_CYC + FLAG_CYC - CNT_ONE;
        end
      end
      ST_RECOVER: begin
        if (s_reg.cnt == '0) begin
          s_next.state = ST_IDLE;
        end
      end
      default: begin
        s_next.state = ST_IDLE;
      end
    endcase
    // hardware set wins over software clear
    if (s_reg.state == ST_IDLE && !start_reset
        && ((start_write && !(s_reg.reset_done && full_ok))
        || (!start_write && start_read && !(s_reg.reset_done && empty_ok))
        || (!start_write && !start_read && start_rewind
        && !(s_reg.reset_done && !expansion_mode)))) begin
      s_next.refused = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '{state: ST_IDLE, cnt: '0, write_n: 1'b1, read_n: 1'b1, reset_n: 1'b1,
                 rewind_n: 1'b1, wdata: '0, rdata: '0, reset_done: 1'b0, refused: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================
  // pin drive
  assign reset_n_in = s_reg.reset_n;
  assign write_strobe_n = s_reg.write_n;
  assign read_strobe_n = s_reg.read_n;
  assign write_data_bus = s_reg.wdata;
  assign first_load_or_rewind_n = expansion_mode ? first_load_level : s_reg.rewind_n;
  // expansion input low for single mode
  assign chain_in_n = expansion_mode;

  // ==========================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_write_gate_full: assert property ($fell(write_strobe_n) |-> $past(full_ok))
    else $error("write strobe fell while full");
  chk_write_after_reset: assert property ($fell(write_strobe_n) |-> s_reg.reset_done)
    else $error("write before device reset");
  chk_data_hold_rise: assert property (
    $rose(write_strobe_n) |-> $stable(write_data_bus) && $past(!write_strobe_n, 1))
    else $error("write data moved at strobe rise");
  chk_reset_setup: assert property (
    $fell(reset_n_in) |-> $past(write_strobe_n && read_strobe_n, 1))
    else $error("strobe low before reset");
  chk_reset_recovery: assert property (
    $rose(reset_n_in) |-> (write_strobe_n && read_strobe_n && busy) [*2])
    else $error("strobe low after reset rise");
  chk_rewind_strobes: assert property (
    (!expansion_mode && !first_load_or_rewind_n) |-> write_strobe_n && read_strobe_n)
    else $error("strobe low during rewind");
  chk_single_chain: assert property (!expansion_mode |-> !chain_in_n)
    else $error("expansion input not low in single mode");
  chk_first_load: assert property (
    expansion_mode |-> first_load_or_rewind_n == first_load_level && chain_in_n)
    else $error("first-load level wrong in chained mode");
  chk_chain_empty: assert property (
    $fell(read_strobe_n) && expansion_mode |-> $past(|empty_ind_n))
    else $error("read while all chained devices empty");
  chk_read_width: assert property ($fell(read_strobe_n) |-> !read_strobe_n ##1 read_strobe_n)
    else $error("read strobe width wrong");

  cov_reset: cover property ($rose(reset_n_in));
  cov_write: cover property ($rose(write_strobe_n));
  cov_read: cover property ($rose(read_strobe_n));
  cov_rewind: cover property ($rose(first_load_or_rewind_n) && !expansion_mode);
endmodule : afc_ctrl

// [logic/afc_pkg.sv]
package afc_pkg;
  localparam int CLK_NS = 50;
  localparam int DATA_W = 9;
  localparam int CHAIN_LEN = 3;
  localparam int CNT_W = 4;
  // ==========================================
  // pin timing in ns
  localparam int STROBE_NS = 35;
  localparam int FLAG_NS = 45;
  localparam int RST_SETUP_NS = 50;
  localparam int RST_PULSE_NS = 50;
  localparam int RST_RECOV_NS = 50;
  localparam int RT_SETUP_NS = 35;
  localparam int RT_PULSE_NS = 35;
  localparam int RT_RECOV_NS = 10;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_min

  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(cyc_min(STROBE_NS));
  localparam logic [CNT_W-1:0] FLAG_CYC = CNT_W'(cyc_min(FLAG_NS));
  localparam logic [CNT_W-1:0] RST_SETUP_CYC = CNT_W'(cyc_min(RST_SETUP_NS));
  localparam logic [CNT_W-1:0] RST_PULSE_CYC = CNT_W'(cyc_min(RST_PULSE_NS));
  localparam logic [CNT_W-1:0] RST_RECOV_CYC = CNT_W'(cyc_min(RST_RECOV_NS));
  localparam logic [CNT_W-1:0] RT_SETUP_CYC = CNT_W'(cyc_min(RT_SETUP_NS));
  localparam logic [CNT_W-1:0] RT_PULSE_CYC = CNT_W'(cyc_min(RT_PULSE_NS));
  localparam logic [CNT_W-1:0] RT_RECOV_CYC = CNT_W'(cyc_min(RT_RECOV_NS));

  // ==========================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDATA = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_EXP_BIT = 0;
  localparam int CTRL_FL_BIT = 1;
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_REWIND_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_EMPTY_BIT = 2;
  localparam int STAT_HALF_BIT = 3;
  localparam int STAT_DONE_BIT = 4;
  localparam int STAT_REFUSED_BIT = 5;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_LOW, ST_RD_LOW, ST_RECOVER, ST_RST_SETUP, ST_RST_LOW,
    ST_RT_SETUP, ST_RT_LOW
  } afc_state_type;
endpackage : afc_pkg

// [logic/afc_ahb_regs.sv]
`timescale 1ns/1ns
module afc_ahb_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic expansion_mode,
  output logic first_load_level,
  output logic [afc_pkg::DATA_W-1:0] wdata,
  output logic start_write,
  output logic start_read,
  output logic start_reset,
  output logic start_rewind,
  output logic clear_refused,
  input wire logic busy,
  input wire logic full_n,
  input wire logic empty_n,
  input wire logic half_n,
  input wire logic reset_done,
  input wire logic refused,
  input wire logic [afc_pkg::DATA_W-1:0] rdata
);
  import afc_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] addr;
    logic [1:0] ctrl;
    logic [DATA_W-1:0] wdata;
    logic [4:0] pulse;
    logic [31:0] hrdata;
  } afc_regs_type;

  afc_regs_type r_reg;
  afc_regs_type r_next;

  // ==========================================
  // bus decode
  always_comb begin
    r_next = r_reg;
    r_next.pulse = '0;
    if (r_reg.wr_pend) begin
      case (r_reg.addr)
        ADDR_CTRL: begin
          r_next.ctrl = hwdata[1:0];
        end
        ADDR_WDATA: begin
          r_next.wdata = hwdata[DATA_W-1:0];
          r_next.pulse[0] = 1'b1;
        end
        ADDR_CMD: begin
          r_next.pulse[1] = hwdata[CMD_READ_BIT];
          r_next.pulse[2] = hwdata[CMD_RESET_BIT];
          r_next.pulse[3] = hwdata[CMD_REWIND_BIT];
        end
        ADDR_STATUS: begin
          r_next.pulse[4] = hwdata[STAT_REFUSED_BIT];
        end
        default: begin
        end
      endcase
    end
    r_next.wr_pend = 1'b0;
    if (hready && hsel && htrans[1]) begin
      r_next.wr_pend = hwrite;
      r_next.addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          ADDR_CTRL: r_next.hrdata = {30'h0000_0000, r_reg.ctrl};
          ADDR_WDATA: r_next.hrdata = {23'h00_0000, r_reg.wdata};
          ADDR_RDATA: r_next.hrdata = {23'h00_0000, rdata};
          ADDR_STATUS: r_next.hrdata = {26'h000_0000, refused, reset_done, half_n, empty_n,
                                        full_n, busy};
          default: r_next.hrdata = WORD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hrdata = r_reg.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign expansion_mode = r_reg.ctrl[CTRL_EXP_BIT];
  assign first_load_level = r_reg.ctrl[CTRL_FL_BIT];
  assign wdata = r_reg.wdata;
  assign start_write = r_reg.pulse[0];
  assign start_read = r_reg.pulse[1];
  assign start_reset = r_reg.pulse[2];
  assign start_rewind = r_reg.pulse[3];
  assign clear_refused = r_reg.pulse[4];
endmodule : afc_ahb_regs

// [testbench/afc_fifo_model.sv]
`timescale 1ns/1ns
module afc_fifo_model #(
  parameter int DEPTH = 8
) (
  input wire logic reset_n_in,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic first_load_or_rewind_n,
  input wire logic chain_in_n,
  input wire logic [afc_pkg::DATA_W-1:0] write_data_bus,
  output logic [afc_pkg::DATA_W-1:0] read_data_bus,
  output logic full_ind_n,
  output logic empty_ind_n,
  output logic chain_out_or_half_full_n,
  output logic [7:0] viol
);
  import afc_pkg::*;
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] HALF = (AW + 1)'(DEPTH / 2);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  logic [DATA_W-1:0] last_q = '0;
  logic powered = 1'b0;
  logic wr_ok = 1'b0;
  logic rd_ok = 1'b0;
  logic half_n = 1'b1;
  logic xo_n = 1'b1;
  initial viol = 8'h00;
  initial read_data_bus = '1;
  // ==========================================
  // flags
  // wrap-bit flags
  assign empty_ind_n = (wptr != rptr);
  assign full_ind_n = ((wptr - rptr) != FULL);
  // half-full in single mode, token pulse when chained
  assign chain_out_or_half_full_n = chain_in_n ? xo_n : half_n;
  // ==========================================
  // pointer events
  // reset clears pointers
  always @(negedge reset_n_in) begin
    wptr = '0;
    rptr = '0;
    half_n = 1'b1;
    powered = 1'b1;
  end
  always @(posedge reset_n_in) begin
    if (!write_strobe_n || !read_strobe_n) viol = viol + 8'h01;
  end
  always @(negedge write_strobe_n) begin
    if (!powered || !reset_n_in) viol = viol + 8'h01;
    wr_ok = full_ind_n;
    if (wr_ok && (wptr - rptr) >= HALF) half_n = 1'b0;
  end
  always @(posedge write_strobe_n) begin
    if (wr_ok) begin
      // token pulse on filling the last location
      if (chain_in_n && wptr[AW-1:0] == AW'(DEPTH - 1)) begin
        xo_n = 1'b0;
        xo_n <= #(CLK_NS) 1'b1;
      end
      mem[wptr[AW-1:0]] = write_data_bus;
      wptr = wptr + 1'b1;
    end
    wr_ok = 1'b0;
  end
  always @(negedge read_strobe_n) begin
    if (!powered) viol = viol + 8'h01;
    rd_ok = empty_ind_n;
    if (rd_ok) begin
      last_q = mem[rptr[AW-1:0]];
      read_data_bus = last_q;
    end
  end
  always @(posedge read_strobe_n) begin
    if (rd_ok) rptr = rptr + 1'b1;
    rd_ok = 1'b0;
    if ((wptr - rptr) <= HALF) half_n = 1'b1;
    read_data_bus = ~last_q;
  end
  always @(negedge first_load_or_rewind_n) begin
    if (!chain_in_n && reset_n_in) begin
      if (!write_strobe_n || !read_strobe_n) viol = viol + 8'h01;
      rptr = '0;
      half_n = !(wptr > HALF);
    end
  end
endmodule : afc_fifo_model

// [testbench/tb.sv]
`timescale 1ns/1ns
module tb;
  import afc_pkg::*;
  localparam int DEPTH = 8;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = WORD_ZERO;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = WORD_ZERO;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] seed = 32'h0000_0042;
  logic hreadyout, hresp, reset_n_in, write_strobe_n, read_strobe_n;
  logic first_load_or_rewind_n, chain_in_n, full_m, empty_m, chain_out_or_half_full_n;
  logic [DATA_W-1:0] write_data_bus;
  logic [DATA_W-1:0] read_data_bus;
  logic [7:0] viol;
  logic [DATA_W-1:0] sent [$];
  logic [DATA_W-1:0] hist [$];
  int fill = 0;
  int err_total = 0;
  int compares = 0;

  always #(CLK_NS / 2) ref_clk = ~ref_clk;

  afc_ctrl i_afc_ctrl (
    .ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .reset_n_in, .write_strobe_n,
    .read_strobe_n, .first_load_or_rewind_n, .chain_in_n, .write_data_bus, .read_data_bus,
    .full_ind_n({2'b11, full_m}), .empty_ind_n({2'b11, empty_m}), .chain_out_or_half_full_n
  );
  afc_fifo_model #(.DEPTH(DEPTH)) i_afc_fifo_model (
    .reset_n_in, .write_strobe_n, .read_strobe_n, .first_load_or_rewind_n, .chain_in_n,
    .write_data_bus, .read_data_bus, .full_ind_n(full_m), .empty_ind_n(empty_m),
    .chain_out_or_half_full_n, .viol
  );

  // ==========================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [5:0] exp_stat(input logic refused);
    return {refused, 1'b1, fill <= DEPTH / 2, fill != 0, fill != DEPTH, 1'b0};
  endfunction : exp_stat

  task automatic tally(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : tally

  task automatic cmp_stat(input logic [5:0] got, input logic [5:0] exp);
    tally(got === exp, 32'(got), 32'(exp));
  endtask : cmp_stat

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, got, exp);
  endtask : cmp_word

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task automatic cmd(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
    repeat (2) @(posedge ref_clk);
    do ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask : cmd

  task automatic chk(input logic refused);
    ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
    cmp_stat(rd[5:0], exp_stat(refused));
  endtask : chk

  task automatic do_write(input logic keep);
    seed = xs(seed);
    cmd(ADDR_WDATA, 32'(seed[8:0]));
    if (keep) begin
      sent.push_back(seed[8:0]);
      hist.push_back(seed[8:0]);
      fill++;
    end
  endtask : do_write

  task automatic do_read(input logic keep);
    cmd(ADDR_CMD, 32'h0000_0002);
    if (keep) begin
      ahb(1'b0, ADDR_RDATA, WORD_ZERO, rd);
      cmp_word(32'(rd[8:0]), 32'(sent.pop_front()));
      fill--;
    end
  endtask : do_read

  task automatic conclude();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // ==========================================
  // scenarios
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    do_write(1'b0);
    ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
    cmp_stat({rd[5:4], 4'h0}, 6'h20);
    cmd(ADDR_STATUS, 32'h0000_0020);
    cmd(ADDR_CMD, 32'h0000_0001);
    chk(1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      do_write(1'b1);
      chk(1'b0);
    end
    do_write(1'b0);
    chk(1'b1);
    cmd(ADDR_STATUS, 32'h0000_0020);
    for (int i = 0; i < DEPTH; i++) begin
      do_read(1'b1);
      chk(1'b0);
    end
    do_read(1'b0);
    chk(1'b1);
    cmd(ADDR_STATUS, 32'h0000_0020);
    do_write(1'b1);
    cmd(ADDR_CMD, 32'h0000_0001);
    fill = 0;
    sent.delete();
    hist.delete();
    chk(1'b0);
    repeat (5) do_write(1'b1);
    repeat (2) do_read(1'b1);
    chk(1'b0);
    cmd(ADDR_CMD, 32'h0000_0004);
    sent = hist;
    fill = hist.size();
    chk(1'b0);
    repeat (5) do_read(1'b1);
    chk(1'b0);
    cmd(ADDR_CTRL, 32'h0000_0003);
    cmp_stat({4'h0, first_load_or_rewind_n, chain_in_n}, 6'h03);
    cmd(ADDR_CTRL, 32'h0000_0001);
    cmp_stat({4'h0, first_load_or_rewind_n, chain_in_n}, 6'h01);
    cmd(ADDR_CMD, 32'h0000_0002);
    cmp_stat(rd[5:0], 6'h1e);
    cmd(ADDR_CMD, 32'h0000_0004);
    ahb(1'b0, ADDR_STATUS, WORD_ZERO, rd);
    cmp_stat(rd[5:0], 6'h3e);
    cmd(ADDR_CTRL, WORD_ZERO);
    cmp_stat({4'h0, first_load_or_rewind_n, chain_in_n}, 6'h02);
    chk(1'b1);
    cmp_word(32'(viol), WORD_ZERO);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule : tb
